// ---- cbl_pkg.sv ----
// Constants and types for the configuration bitstream loader.
// Assumes a 100 MHz system clock; all pins arrive asynchronously.
`default_nettype none
package cbl_pkg;
  // Mode pin codes {bit2, bit1, bit0}
  typedef enum logic [2:0] {
    CBL_MSER = 3'h0,
    CBL_RSV1 = 3'h1,
    CBL_RSV2 = 3'h2,
    CBL_PSYN = 3'h3,
    CBL_MPUP = 3'h4,
    CBL_PASY = 3'h5,
    CBL_MPDN = 3'h6,
    CBL_SSER = 3'h7
  } cbl_mode_e;
  typedef enum logic [2:0] {
    ST_WINIT = 3'h0,
    ST_SAMPLE = 3'h1,
    ST_HDR = 3'h3,
    ST_LEN = 3'h2,
    ST_FRM = 3'h6,
    ST_FWD = 3'h7,
    ST_DONE = 3'h5,
    ST_ERR = 3'h4
  } cbl_state_e;
  typedef enum logic [1:0] {
    PH_START = 2'h0,
    PH_DATA = 2'h1,
    PH_CHK = 2'h3
  } cbl_phase_e;
  // Eight leading ones followed by the preamble
  localparam logic [11:0] HDR_PATTERN = 12'hff2;
  localparam logic [3:0] CHK_FIXED = 4'h6;
  localparam logic [7:0] POSTAMBLE = 8'h7f;
  localparam int LEN_W = 24;
  localparam logic [17:0] ADDR_UP_START = 18'h00000;
  localparam logic [17:0] ADDR_DN_START = 18'h3ffff;
  localparam int ROWS_DEF = 10;
  localparam int COLS_DEF = 10;
  localparam int ROW_BITS = 10;
  localparam int TOP_BITS = 7;
  localparam int BOT_BITS = 13;
  localparam int PAD_BITS = 1;
  localparam int CHK_BITS = 4;
  localparam int LAST_CHK_BITS = 11;
  localparam int COL_FRAMES = 36;
  localparam int LEFT_FRAMES = 26;
  localparam int RIGHT_FRAMES = 41;
  localparam int PAD_FRAMES = 1;
  localparam int CLK_PERIOD_NS = 10;
  localparam int OSC_PERIOD_NS = 125;
  localparam int OSC_HALF_CYC = OSC_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int MODE_SAMPLE_DLY = 2;
  // Must match the bitstream generator
  localparam logic [10:0] CRC_POLY = 11'h005;
  localparam logic [10:0] CRC_SEED = 11'h000;
endpackage
`default_nettype wire

// ---- cbl_loader.sv ----
// Configuration bitstream loader: mode decode, byte serializer, header and
// frame parser, daisy-chain output and start-up trigger.
// Assumes all pins are asynchronous to clk and the link clock is slow.
// Overview of operation
// - Sample mode pins, decode six modes
// - Master serial drives clock, takes serial data
// - Master parallel drives address up or down
// - Async peripheral bursts internal clock per byte
// - Sync peripheral serializes on external clock
// - Peripheral modes show ready, host waits
// - Slave samples rising, forwards on falling edge
// - Ones, preamble, 24-bit length, separator ones
// - Frame is start zero, data, check
// - Without CRC check field must be 0110
// - With CRC compare running CRC, last 11
// - Postamble closes the bitstream
// - Frame error halts loading, pulls init low
// - Master clock and address keep running
// - Pass header through, capture length count
// - Hold daisy output high during own frames
// - Forward later frames downstream
// - Start-up when clock count equals length
// - Extra ones are counted in length
// - Frame size and count from rows, columns
// - Mode pins become user inputs, output
// - Sample mode two clocks after init high
`timescale 1ns/1ps
`default_nettype none
module cbl_loader #(
  parameter int ROWS = cbl_pkg::ROWS_DEF,
  parameter int COLS = cbl_pkg::COLS_DEF
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic mode_select_bit0,
  input wire logic mode_select_bit1,
  input wire logic mode_select_bit2,
  output logic mode1_pin_o,
  output logic mode1_pin_oe,
  input wire logic configuration_clock_i,
  output logic configuration_clock_o,
  output logic configuration_clock_oe,
  input wire logic din,
  output logic dout,
  input wire logic [7:0] pdata,
  input wire logic pwrite,
  output logic ready,
  output logic [17:0] prom_addr,
  input wire logic init_n_i,
  output logic init_n_o,
  output logic init_n_oe,
  input wire logic program_n,
  input wire logic mem_init_done,
  input wire logic crc_enable,
  output logic configured,
  output logic frame_error,
  output logic [23:0] length_count,
  output logic aux_mode_input_0,
  output logic aux_mode_input_2,
  input wire logic aux_mode_output_1,
  input wire logic aux_mode_output_1_tristate
);
  localparam int DBITS = cbl_pkg::ROW_BITS * ROWS + cbl_pkg::TOP_BITS
                       + cbl_pkg::BOT_BITS + cbl_pkg::PAD_BITS;
  localparam int NFRAMES = cbl_pkg::COL_FRAMES * COLS + cbl_pkg::LEFT_FRAMES
                         + cbl_pkg::RIGHT_FRAMES + cbl_pkg::PAD_FRAMES;
  localparam logic [10:0] DLEN = 11'(DBITS - 1);
  localparam logic [10:0] DLEN_LAST = 11'(DBITS - 1 - (cbl_pkg::LAST_CHK_BITS
                                      - cbl_pkg::CHK_BITS));
  localparam logic [11:0] NFR_LAST = 12'(NFRAMES - 1);

  // LFSR step, polynomial and seed in the package
  function automatic logic [10:0] crc_step(input logic [10:0] c, input logic b);
    crc_step = {c[9:0], 1'b0} ^ ((c[10] ^ b) ? cbl_pkg::CRC_POLY : 11'h000);
  endfunction

  logic [15:0] sync1_q, sync2_q;
  logic configuration_clock_prev_q, pwr_prev_q;
  cbl_pkg::cbl_state_e st_q;
  cbl_pkg::cbl_phase_e ph_q;
  cbl_pkg::cbl_mode_e mode_q;
  logic [1:0] dly_q;
  logic [3:0] osc_cnt_q;
  logic configuration_clock_int_q;
  logic [7:0] sh_q, buf_q;
  logic [2:0] bcnt_q;
  logic byte_vld_q, buf_full_q;
  logic [17:0] addr_q;
  logic [11:0] hdr_q;
  logic [23:0] len_q, clk_cnt_q;
  logic [10:0] bitcnt_q, chk_q, crc_q;
  logic [11:0] frcnt_q;
  logic lastbit_q, pass_q, dout_q;

  // Mode, init, program, clock, data and write pins pass two flip-flops; only sync2_q is read
  wire [15:0] pin_raw = {pdata, pwrite, din, configuration_clock_i, program_n,
                         init_n_i, mode_select_bit2, mode_select_bit1,
                         mode_select_bit0};
  wire [2:0] mode_pins = sync2_q[2:0];
  wire init_hi = sync2_q[3];
  wire prog_n_s = sync2_q[4];
  wire configuration_clock_s = sync2_q[5];
  wire din_s = sync2_q[6];
  wire pwr_s = sync2_q[7];
  wire [7:0] pdata_s = sync2_q[15:8];

  wire active = st_q != cbl_pkg::ST_WINIT && st_q != cbl_pkg::ST_SAMPLE;
  wire rsv = mode_pins == cbl_pkg::CBL_RSV1 || mode_pins == cbl_pkg::CBL_RSV2;
  wire m_mpar = mode_q == cbl_pkg::CBL_MPUP || mode_q == cbl_pkg::CBL_MPDN;
  wire m_master = m_mpar || mode_q == cbl_pkg::CBL_MSER;
  wire m_serial = mode_q == cbl_pkg::CBL_MSER || mode_q == cbl_pkg::CBL_SSER;
  wire m_pasy = mode_q == cbl_pkg::CBL_PASY;
  wire m_periph = m_pasy || mode_q == cbl_pkg::CBL_PSYN;
  wire m_ext_clk = mode_q == cbl_pkg::CBL_SSER || mode_q == cbl_pkg::CBL_PSYN;

  // Internal oscillator runs free so master clocks never freeze
  wire osc_wrap = osc_cnt_q == 4'(cbl_pkg::OSC_HALF_CYC - 1);
  // async peripheral clocks only while a byte is pending
  wire burst_on = m_pasy && (byte_vld_q || buf_full_q);
  wire int_gate = m_master || burst_on;
  // external clock edges found by the system clock
  // rising edge samples, falling edge forwards
  wire ext_rise = configuration_clock_s && !configuration_clock_prev_q;
  wire ext_fall = !configuration_clock_s && configuration_clock_prev_q;
  wire rise = m_ext_clk ? ext_rise : (osc_wrap && !configuration_clock_int_q && int_gate);
  wire fall = m_ext_clk ? ext_fall : (osc_wrap && configuration_clock_int_q && int_gate);

  // bytes serialized MSB first, first bit taken straight from the source
  wire take = !m_serial && !byte_vld_q && (m_mpar || buf_full_q);
  wire [7:0] src = m_mpar ? pdata_s : buf_q;
  wire bit_avail = m_serial || byte_vld_q || take;
  wire cur_bit = m_serial ? din_s : (byte_vld_q ? sh_q[7] : src[7]);
  wire step = rise && bit_avail && active;
  wire wr_evt = pwr_s && !pwr_prev_q;
  wire buf_load = wr_evt && m_periph && active && (!buf_full_q || (step && take));
  wire [17:0] addr_next = (mode_q == cbl_pkg::CBL_MPDN) ? addr_q - 18'h00001
                                                        : addr_q + 18'h00001;

  // frame fields; last frame trades 7 data bits for 11 check bits
  wire last_fr = frcnt_q == NFR_LAST;
  wire [10:0] dlen = last_fr ? DLEN_LAST : DLEN;
  wire [10:0] cw = last_fr ? 11'(cbl_pkg::LAST_CHK_BITS - 1)
                           : 11'(cbl_pkg::CHK_BITS - 1);
  wire [10:0] chk_full = {chk_q[9:0], cur_bit};
  wire chk_end = st_q == cbl_pkg::ST_FRM && ph_q == cbl_pkg::PH_CHK && bitcnt_q == cw;
  // four partial bits, or eleven on the last frame with CRC on
  wire chk_good = !crc_enable ? chk_full[3:0] == cbl_pkg::CHK_FIXED
                : last_fr ? chk_full == crc_q
                : chk_full[3:0] == crc_q[3:0];
  wire hdr_hit = {hdr_q[10:0], cur_bit} == cbl_pkg::HDR_PATTERN;
  // every clock, extra ones included, counts toward the length
  wire len_met = clk_cnt_q == len_q;
  wire restart = srst || !prog_n_s;

  always_ff @(posedge clk) begin
    if (srst) begin
      sync1_q <= 16'h0000;
      sync2_q <= 16'h0000;
      configuration_clock_prev_q <= 1'b0;
      pwr_prev_q <= 1'b0;
      osc_cnt_q <= 4'h0;
      configuration_clock_int_q <= 1'b0;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      configuration_clock_prev_q <= configuration_clock_s;
      pwr_prev_q <= pwr_s;
      osc_cnt_q <= osc_wrap ? 4'h0 : osc_cnt_q + 4'h1;
      if (osc_wrap) begin
        configuration_clock_int_q <= !configuration_clock_int_q;
      end
    end
  end

  // Byte serializer, peripheral holding buffer and PROM address
  always_ff @(posedge clk) begin
    if (restart) begin
      sh_q <= 8'h00;
      bcnt_q <= 3'h0;
      byte_vld_q <= 1'b0;
      buf_q <= 8'h00;
      buf_full_q <= 1'b0;
      addr_q <= cbl_pkg::ADDR_UP_START;
    end else begin
      if (st_q == cbl_pkg::ST_SAMPLE) begin
        addr_q <= (mode_pins == cbl_pkg::CBL_MPDN) ? cbl_pkg::ADDR_DN_START
                                                   : cbl_pkg::ADDR_UP_START;
      end
      if (step && take) begin
        sh_q <= {src[6:0], 1'b0};
        bcnt_q <= 3'h1;
        byte_vld_q <= 1'b1;
        buf_full_q <= 1'b0;
        // address keeps stepping even after an error
        if (m_mpar) begin
          addr_q <= addr_next;
        end
      end else if (step && byte_vld_q) begin
        sh_q <= {sh_q[6:0], 1'b0};
        bcnt_q <= bcnt_q + 3'h1;
        byte_vld_q <= bcnt_q != 3'h7;
      end
      // a write is taken while ready or when the buffer drains in the same cycle; set wins over the drain
      if (buf_load) begin
        buf_q <= pdata_s;
        buf_full_q <= 1'b1;
      end
    end
  end

  // Mode sampling, header, length and frame parser
  always_ff @(posedge clk) begin
    // program pulse restarts the whole load
    if (restart) begin
      st_q <= cbl_pkg::ST_WINIT;
      ph_q <= cbl_pkg::PH_START;
      mode_q <= cbl_pkg::CBL_MSER;
      dly_q <= 2'h0;
      hdr_q <= 12'h000;
      len_q <= 24'h000000;
      clk_cnt_q <= 24'h000000;
      bitcnt_q <= 11'h000;
      frcnt_q <= 12'h000;
      chk_q <= 11'h000;
      crc_q <= cbl_pkg::CRC_SEED;
      lastbit_q <= 1'b1;
      pass_q <= 1'b1;
    end else begin
      if (step) begin
        clk_cnt_q <= clk_cnt_q + 24'h000001;
        lastbit_q <= cur_bit;
        pass_q <= st_q == cbl_pkg::ST_HDR || st_q == cbl_pkg::ST_LEN
               || st_q == cbl_pkg::ST_FWD || st_q == cbl_pkg::ST_DONE;
      end
      case (st_q)
        cbl_pkg::ST_WINIT: begin
          // two clocks after init is seen high
          dly_q <= init_hi ? dly_q + 2'h1 : 2'h0;
          if (init_hi && dly_q == 2'(cbl_pkg::MODE_SAMPLE_DLY - 1)) begin
            st_q <= cbl_pkg::ST_SAMPLE;
          end
        end
        cbl_pkg::ST_SAMPLE: begin
          // latch the mode; reserved codes refuse to load
          mode_q <= cbl_pkg::cbl_mode_e'(mode_pins);
          st_q <= rsv ? cbl_pkg::ST_ERR : cbl_pkg::ST_HDR;
        end
        cbl_pkg::ST_HDR: begin
          if (step) begin
            hdr_q <= {hdr_q[10:0], cur_bit};
            bitcnt_q <= 11'h000;
            if (hdr_hit) begin
              st_q <= cbl_pkg::ST_LEN;
            end
          end
        end
        cbl_pkg::ST_LEN: begin
          if (step) begin
            len_q <= {len_q[22:0], cur_bit};
            bitcnt_q <= bitcnt_q + 11'h001;
            if (bitcnt_q == 11'(cbl_pkg::LEN_W - 1)) begin
              st_q <= cbl_pkg::ST_FRM;
              ph_q <= cbl_pkg::PH_START;
            end
          end
        end
        cbl_pkg::ST_FRM: begin
          if (step) begin
            case (ph_q)
              // Separator and trailing dummy ones are skipped here
              cbl_pkg::PH_START: begin
                if (!cur_bit) begin
                  ph_q <= cbl_pkg::PH_DATA;
                  bitcnt_q <= 11'h000;
                end
              end
              cbl_pkg::PH_DATA: begin
                crc_q <= crc_step(crc_q, cur_bit);
                bitcnt_q <= bitcnt_q + 11'h001;
                if (bitcnt_q == dlen) begin
                  ph_q <= cbl_pkg::PH_CHK;
                  bitcnt_q <= 11'h000;
                end
              end
              default: begin
                chk_q <= chk_full;
                bitcnt_q <= bitcnt_q + 11'h001;
                if (chk_end) begin
                  ph_q <= cbl_pkg::PH_START;
                  frcnt_q <= frcnt_q + 12'h001;
                  // any bad check halts the load
                  if (!chk_good) begin
                    st_q <= cbl_pkg::ST_ERR;
                  end else if (last_fr) begin
                    st_q <= cbl_pkg::ST_FWD;
                  end
                end
              end
            endcase
          end
        end
        cbl_pkg::ST_FWD: begin
          // start-up once the clock count reaches the length
          // the postamble is counted and forwarded like any bit
          if (len_met) begin
            st_q <= cbl_pkg::ST_DONE;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (restart) begin
      dout_q <= 1'b1;
    end else if (fall && active) begin
      dout_q <= pass_q ? lastbit_q : 1'b1;
    end
  end

  // master modes and async burst drive the clock
  assign configuration_clock_o = configuration_clock_int_q && int_gate;
  assign configuration_clock_oe = active && (m_master || m_pasy);
  assign dout = dout_q;
  assign ready = m_periph && active && !buf_full_q;
  assign prom_addr = addr_q;
  // open-drain init held low until cleared memory or on error
  assign init_n_o = 1'b0;
  assign init_n_oe = !mem_init_done || st_q == cbl_pkg::ST_ERR;
  assign configured = st_q == cbl_pkg::ST_DONE;
  assign frame_error = st_q == cbl_pkg::ST_ERR;
  assign length_count = len_q;
  // mode pins turn into user signals after start-up
  assign aux_mode_input_0 = configured && mode_pins[0];
  assign aux_mode_input_2 = configured && mode_pins[2];
  assign mode1_pin_o = aux_mode_output_1;
  assign mode1_pin_oe = configured && !aux_mode_output_1_tristate;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  mode_hold_a: assert property (active && $past(active) |-> $stable(mode_q))
    else $error("mode changed during load");
  sample_delay_a: assert property (st_q == cbl_pkg::ST_SAMPLE |->
    $past(init_hi, 1) && $past(init_hi, 2))
    else $error("mode sampled too early");
  reserved_mode_a: assert property (st_q == cbl_pkg::ST_SAMPLE && rsv
    && prog_n_s |=> st_q == cbl_pkg::ST_ERR)
    else $error("reserved mode not refused");
  error_init_a: assert property (st_q == cbl_pkg::ST_ERR |-> init_n_oe && !init_n_o)
    else $error("init not pulled low on error");
  fixed_check_a: assert property (step && chk_end && !crc_enable && prog_n_s
    && chk_full[3:0] != cbl_pkg::CHK_FIXED |=> st_q == cbl_pkg::ST_ERR)
    else $error("bad check field accepted");
  dout_high_a: assert property (st_q == cbl_pkg::ST_FRM && ph_q == cbl_pkg::PH_DATA
    && fall && prog_n_s |=> dout_q)
    else $error("own frame data leaked downstream");
  clock_runs_a: assert property (st_q == cbl_pkg::ST_ERR && m_master
    |-> ##[1:16] $rose(configuration_clock_o))
    else $error("master clock stopped after error");
  startup_count_a: assert property ($rose(st_q == cbl_pkg::ST_DONE)
    |-> $past(len_met))
    else $error("start-up before length reached");
  write_taken_a: assert property (wr_evt && ready && prog_n_s |=> buf_full_q)
    else $error("write while ready was lost");
  addr_start_a: assert property (st_q == cbl_pkg::ST_HDR
    && $past(st_q) == cbl_pkg::ST_SAMPLE && mode_q == cbl_pkg::CBL_MPDN
    |-> addr_q == cbl_pkg::ADDR_DN_START)
    else $error("down address start wrong");
  preamble_a: assert property (st_q == cbl_pkg::ST_HDR && step && hdr_hit
    && prog_n_s |=> st_q == cbl_pkg::ST_LEN)
    else $error("preamble not recognized");
endmodule // cbl_loader
`default_nettype wire

// ---- cbl_src.sv ----
// Far-side model of the loader: serial bit source for slave and master serial.
// Assumes the bench owns byte data and the pull-up of the open-drain pins.
`timescale 1ns/1ps
`default_nettype none
module cbl_src (
  input wire logic ccw,
  input wire logic master,
  input wire logic dout,
  output logic ext_clk,
  output logic din
);
  logic q[$];
  logic capq[$];

  initial begin
    ext_clk = 1'b0;
    din = 1'b1;
  end

  // Released line shows the inverse, never a held value
  task automatic next_bit();
    if (q.size() > 0) begin
      din = q.pop_front();
    end else begin
      din = ~din;
    end
  endtask

  // external link clock, 80 ns period, still between calls
  task automatic clock_out(input int n);
    repeat (n) begin
      next_bit();
      #40;
      ext_clk = 1'b1;
      #40;
      ext_clk = 1'b0;
    end
  endtask

  // Downstream device captures on the rising link edge
  always @(posedge ccw) begin
    capq.push_back(dout);
  end

  // Serial memory steps on falling edge, moved to the bench edge
  always @(negedge ccw) begin
    if (master) begin
      #5;
      next_bit();
    end
  end
endmodule // cbl_src
`default_nettype wire

// ---- tb_cbl_loader.sv ----
// Self-checking bench for the loader: slave, master and peripheral loading.
// Assumes the far-side model drives link clock and serial data.
`timescale 1ns/1ps
`default_nettype none
module tb_cbl_loader;
  localparam int DBITS = 10 * 1 + 21;
  logic clk, srst, mode_select_bit0, mode_select_bit1, mode_select_bit2;
  logic din, dout, pwrite, ready, program_n, crc_enable, init_ext_low, master;
  logic ext_clk, configuration_clock_o, configuration_clock_oe, ccw, init_n_i;
  logic init_n_o, init_n_oe, configured, frame_error, mode1_pin_o, mode1_pin_oe;
  logic aux_mode_input_0, aux_mode_input_2;
  logic mem_done, aux_o, aux_t;
  logic [7:0] pdata;
  logic [17:0] prom_addr, addr_ref;
  logic [23:0] length_count;
  logic [2:0] mon;
  logic expq[$];
  int n_fail, num_checks, tog;
  logic prev;

  assign ccw = configuration_clock_oe ? configuration_clock_o : ext_clk;
  assign init_n_i = !(init_n_oe || init_ext_low);
  assign mon = {prom_addr !== addr_ref, ready, frame_error};

  cbl_loader #(.ROWS(1), .COLS(1)) u_dut (.clk(clk), .srst(srst),
    .mode_select_bit0(mode_select_bit0), .mode_select_bit1(mode_select_bit1),
    .mode_select_bit2(mode_select_bit2), .mode1_pin_o(mode1_pin_o),
    .mode1_pin_oe(mode1_pin_oe), .configuration_clock_i(ccw),
    .configuration_clock_o(configuration_clock_o),
    .configuration_clock_oe(configuration_clock_oe), .din(din), .dout(dout),
    .pdata(pdata), .pwrite(pwrite), .ready(ready), .prom_addr(prom_addr),
    .init_n_i(init_n_i), .init_n_o(init_n_o), .init_n_oe(init_n_oe),
    .program_n(program_n), .mem_init_done(mem_done), .crc_enable(crc_enable),
    .configured(configured), .frame_error(frame_error), .length_count(length_count),
    .aux_mode_input_0(aux_mode_input_0), .aux_mode_input_2(aux_mode_input_2),
    .aux_mode_output_1(aux_o), .aux_mode_output_1_tristate(aux_t));

  cbl_src u_src (.ccw(ccw), .master(master), .dout(dout), .ext_clk(ext_clk), .din(din));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_bit(input int idx, input logic val, input int lim);
    int i;
    i = 0;
    while (mon[idx] !== val && i < lim) begin
      @(negedge clk);
      i++;
    end
    if (mon[idx] !== val) begin
      n_fail++;
      $display("mismatch at %0t: wait ran out", $time);
      print_verdict();
    end
  endtask

  // Reset, then release init so the mode pins are sampled
  task automatic start(input logic [2:0] code);
    @(negedge clk);
    {mode_select_bit2, mode_select_bit1, mode_select_bit0} = code;
    master = (code == 3'h0);
    srst = 1'b1;
    init_ext_low = 1'b1;
    repeat (10) @(negedge clk);
    srst = 1'b0;
    if (master) u_src.next_bit();
    repeat (5) @(negedge clk);
    init_ext_low = 1'b0;
    repeat (8) @(negedge clk);
  endtask

  // ones, preamble, length MSB first, separator
  task automatic push_hdr(input logic [23:0] len);
    u_src.q.delete();
    u_src.capq.delete();
    repeat (8) u_src.q.push_back(1'b1);
    for (int i = 3; i >= 0; i--) u_src.q.push_back(4'h2 >> i);
    for (int i = 23; i >= 0; i--) u_src.q.push_back(len[i]);
    repeat (4) u_src.q.push_back(1'b1);
  endtask

  task automatic push_frame(input logic [3:0] chk);
    u_src.q.push_back(1'b0);
    for (int i = 0; i < DBITS; i++) u_src.q.push_back(i[0]);
    for (int i = 3; i >= 0; i--) u_src.q.push_back(chk[i]);
  endtask

  // host waits for ready before each byte
  task automatic host_write(input logic [7:0] b);
    wait_bit(1, 1'b1, 400);
    pdata = b;
    pwrite = 1'b1;
    repeat (4) @(negedge clk);
    pwrite = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  initial begin
    {srst, mode_select_bit0, mode_select_bit1, mode_select_bit2} = 4'h8;
    {pwrite, crc_enable, master} = 3'h0;
    program_n = 1'b1;
    init_ext_low = 1'b1;
    {mem_done, aux_o, aux_t} = 3'h6;
    pdata = 8'hff;
    addr_ref = 18'h00000;
    n_fail = 0;
    num_checks = 0;
    // Slave serial: pass-through, hold high, good then bad check field
    push_hdr(24'h5a3c96);
    push_frame(4'h6);
    push_frame(4'h5);
    expq = u_src.q;
    start(3'h7);
    {mode_select_bit2, mode_select_bit1, mode_select_bit0} = 3'h0;
    u_src.clock_out(76);
    check(frame_error, 1'b0);
    u_src.clock_out(36);
    check(length_count, 24'h5a3c96);
    for (int i = 1; i < 40; i++) check(u_src.capq[i], expq[i - 1]);
    for (int i = 41; i < 112; i++) check(u_src.capq[i], 1'b1);
    wait_bit(0, 1'b1, 40);
    check(init_n_i, 1'b0);
    check(configuration_clock_oe, 1'b0);
    check({configured, aux_mode_input_0, mode1_pin_oe, mode1_pin_o}, 4'h1);
    program_n = 1'b0;
    repeat (4) @(negedge clk);
    program_n = 1'b1;
    wait_bit(0, 1'b0, 20);
    check(init_n_oe, 1'b0);
    // User pin 1 stays undriven before start-up, value follows user net
    {aux_o, aux_t} = 2'h0;
    @(negedge clk);
    check({mode1_pin_o, mode1_pin_oe}, 2'h0);
    // Memory clear still running keeps init pulled low
    mem_done = 1'b0;
    @(negedge clk);
    check(init_n_oe, 1'b1);
    {mem_done, aux_o} = 2'h3;
    // Reserved codes
    for (int c = 1; c < 3; c++) begin
      start(c[2:0]);
      wait_bit(0, 1'b1, 20);
      check(init_n_oe, 1'b1);
    end
    // Master serial: bad frame, then clock keeps running
    push_hdr(24'h0f1e2d);
    push_frame(4'h9);
    // Extra leading one: the clock pin may show one edge before the first bit
    u_src.q.push_front(1'b1);
    start(3'h0);
    check(configuration_clock_oe, 1'b1);
    wait_bit(0, 1'b1, 1500);
    check(length_count, 24'h0f1e2d);
    tog = 0;
    for (int i = 0; i < 120; i++) begin
      prev = configuration_clock_o;
      @(negedge clk);
      if (configuration_clock_o !== prev) tog++;
    end
    check({23'h0, tog >= 16}, 24'h1);
    // Master parallel up and down: first address step
    crc_enable = 1'b1;
    for (int c = 4; c < 7; c += 2) begin
      addr_ref = (c == 4) ? 18'h00000 : 18'h3ffff;
      start(c[2:0]);
      wait_bit(2, 1'b1, 300);
      check(prom_addr, (c == 4) ? 18'h00001 : 18'h3fffe);
      check(configuration_clock_oe, 1'b1);
    end
    addr_ref = prom_addr;
    crc_enable = 1'b0;
    // Peripheral sync then async: two bytes each
    for (int c = 3; c < 6; c += 2) begin
      start(c[2:0]);
      check(ready, 1'b1);
      for (int k = 0; k < 2; k++) begin
        host_write(k ? 8'h3c : 8'ha5);
        if (c == 3) u_src.clock_out(12);
        else repeat (150) @(negedge clk);
      end
      wait_bit(1, 1'b1, 400);
      check(configuration_clock_oe, c == 5);
    end
    print_verdict();
  end
endmodule // tb_cbl_loader
`default_nettype wire
